// File: hdl/iac_checker.sv
// Module: illegal access checker with error capture and Avalon-MM registers
//
// Operation
// R1: Every access is classified; any access to unmapped space is illegal.
// R2: Register space: core/debug read and write ok; ADC and execution illegal.
// R3: RAM all ok (code allows RAM execute by core only); EEPROM/flash read and core execute; info rows core/debug read.
// R4: Reserved: reads core/debug, debug writes, core writes in special mode only.
// R5: Unsupported NVM access during an NVM command is illegal.
// R6: Illegal core access raises a machine exception request.
// R7: Illegal debug access sets the debug illegal access flag.
// R8: Illegal ADC access raises the ADC error interrupt.
// R9: Illegal core prefetch raises machine exception even if never executed.
// R10: Software keeps code out of the top 8 bytes of memories.
// R11: Uncorrectable ECC in core or ADC access raises machine exception.
// R12: Uncorrectable ECC in debug access sets write-fail or read-invalid flag.
// R13: First core violation or ECC error captures initiator, target, access, error.
// R14: Error type 1 means illegal address, 2 means uncorrectable ECC.
// R15: Nonzero capture is frozen; writing 0xFFFF clears it.
// R16: Permission decided combinationally in the cycle of the access.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps

module iac_checker (
  // Clock and reset
  input  wire logic                    mclk_i,
  input  wire logic                    rst_i,
  // Monitored access
  input  wire iac_pkg::iac_access_t    acc_i,
  input  wire iac_pkg::iac_cpu_state_t cpu_i,
  input  wire logic                    special_mode_i,
  // Verdicts
  output logic                         illegal_o,
  output logic                         machine_exc_o,
  output logic                         adc_err_irq_o,
  output logic                         debug_illegal_access_flag_o,
  output logic                         debug_ram_write_fail_flag_o,
  output logic                         debug_read_invalid_flag_o,
  // Avalon-MM slave
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  // Interrupt
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Permission decision
  logic          legal;
  logic          illegal;
  logic          ecc_evt;
  logic          is_core;
  logic          is_dbg;
  logic          is_adc;
  logic          is_rd;
  logic          is_wr;
  logic          is_ex;

  assign is_core = acc_i.ini == iac_pkg::IAC_INI_CORE;
  assign is_dbg  = acc_i.ini == iac_pkg::IAC_INI_DEBUG;
  assign is_adc  = acc_i.ini == iac_pkg::IAC_INI_ADC;
  assign is_rd   = acc_i.kind == iac_pkg::IAC_ACC_READ || acc_i.kind == iac_pkg::IAC_ACC_VECT;
  assign is_wr   = acc_i.kind == iac_pkg::IAC_ACC_WRITE;
  assign is_ex   = acc_i.kind == iac_pkg::IAC_ACC_EXEC;

  // R16: combinational decision
  always_comb begin
    legal = 1'b0;
    case (acc_i.rgn)
      // R2: register space
      iac_pkg::IAC_RGN_REGS:   legal = (is_rd | is_wr) & ~is_adc;
      // R3: region permissions
      iac_pkg::IAC_RGN_RAM:    legal = is_rd | is_wr | (is_ex & is_core);
      iac_pkg::IAC_RGN_EEPROM: legal = is_rd | (is_ex & is_core);
      iac_pkg::IAC_RGN_PFLASH: legal = is_rd | (is_ex & is_core);
      iac_pkg::IAC_RGN_INFO:   legal = is_rd & ~is_adc;
      // R4: reserved spaces
      iac_pkg::IAC_RGN_RSVD:   legal = ~is_adc & (is_rd | (is_wr & (is_dbg | special_mode_i)));
      iac_pkg::IAC_RGN_RSVDRO: legal = is_rd & ~is_adc;
      // R1: unmapped always illegal
      default:                 legal = 1'b0;
    endcase
    // R5: NVM collision
    if (acc_i.nvm_unsup) begin
      legal = 1'b0;
    end
  end

  assign illegal = acc_i.valid & ~legal;
  assign ecc_evt = acc_i.valid & acc_i.ecc_fail;
  assign illegal_o = illegal;

  ////////////////////////////////////////////////////////////////////////////
  // Reporting per initiator
  // R6: core machine exception, R9: includes prefetch, R11: ECC core/ADC
  assign machine_exc_o = (illegal & is_core) | (ecc_evt & (is_core | is_adc));
  // R8: ADC error interrupt
  assign adc_err_irq_o = illegal & is_adc;
  // R7: debug illegal flag
  assign debug_illegal_access_flag_o = illegal & is_dbg;
  // R12: debug ECC flags
  assign debug_ram_write_fail_flag_o = ecc_evt & is_dbg & is_wr;
  assign debug_read_invalid_flag_o   = ecc_evt & is_dbg & ~is_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Error capture
  logic [15:0]              error_code_capture_reg;
  iac_pkg::iac_cpu_state_t  cap_cpu_reg;
  logic                     cap_evt;
  logic                     clr_wr;
  logic [15:0]              code_next;
  logic [3:0]               tgt;
  logic [3:0]               act;

  // R13: core violation or ECC of core/ADC
  assign cap_evt = (illegal & is_core) | (ecc_evt & (is_core | is_adc));
  assign clr_wr  = avs_write & avs_address == iac_pkg::IAC_OFF_ERRCODE
                   & avs_byteenable[1:0] == 2'h3 & avs_writedata[15:0] == iac_pkg::IAC_CLEAR_KEY;

  always_comb begin
    case (acc_i.rgn)
      iac_pkg::IAC_RGN_REGS:   tgt = iac_pkg::IAC_TGT_REGS;
      iac_pkg::IAC_RGN_RAM:    tgt = iac_pkg::IAC_TGT_RAM;
      iac_pkg::IAC_RGN_EEPROM: tgt = iac_pkg::IAC_TGT_EEPROM;
      iac_pkg::IAC_RGN_PFLASH: tgt = iac_pkg::IAC_TGT_PFLASH;
      iac_pkg::IAC_RGN_INFO:   tgt = iac_pkg::IAC_TGT_INFO;
      default:                 tgt = iac_pkg::IAC_CODE_NONE;
    endcase
    case (acc_i.kind)
      iac_pkg::IAC_ACC_EXEC:  act = iac_pkg::IAC_ACT_OPCODE;
      iac_pkg::IAC_ACC_VECT:  act = iac_pkg::IAC_ACT_VECTOR;
      iac_pkg::IAC_ACC_WRITE: act = iac_pkg::IAC_ACT_STORE;
      default:                act = iac_pkg::IAC_ACT_LOAD;
    endcase
  end

  // R13: initiator, target, access, error codes; R14: error type
  assign code_next = {is_core ? iac_pkg::IAC_ITR_CORE : iac_pkg::IAC_ITR_ADC, tgt, act,
                      illegal ? iac_pkg::IAC_ERR_ILLEGAL : iac_pkg::IAC_ERR_ECC};

  // R15: freeze while nonzero, clear by key (new event wins)
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      error_code_capture_reg <= iac_pkg::IAC_ERRCODE_RST;
      cap_cpu_reg            <= '0;
    end else if (cap_evt && (error_code_capture_reg == iac_pkg::IAC_ERRCODE_RST || clr_wr)) begin
      error_code_capture_reg <= code_next;
      cap_cpu_reg            <= cpu_i;
    end else if (clr_wr) begin
      error_code_capture_reg <= iac_pkg::IAC_ERRCODE_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, enable, clear
  logic [3:0] status_reg;
  logic [3:0] enable_reg;
  logic [3:0] evt_vec;
  logic [3:0] clr_vec;

  assign evt_vec = {illegal & is_adc, illegal & is_dbg, ecc_evt, illegal & is_core};
  assign clr_vec = (avs_write && avs_address == iac_pkg::IAC_OFF_STATUS) ? avs_writedata[11:8] : 4'h0;

  // Set wins over clear
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~clr_vec) | evt_vec;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= 4'h0;
    end else if (avs_write && avs_address == iac_pkg::IAC_OFF_STATUS && avs_byteenable[2]) begin
      enable_reg <= avs_writedata[19:16];
    end
  end

  assign irq_o = |(status_reg & enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon read data, one wait state on reads
  logic rd_ack_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= avs_read & ~rd_ack_reg;
    end
  end

  // Read stalls once while data is registered
  assign avs_waitrequest = avs_read & ~rd_ack_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_ack_reg) begin
      case (avs_address)
        iac_pkg::IAC_OFF_ERRCODE: avs_readdata <= {16'h0000, error_code_capture_reg};
        iac_pkg::IAC_OFF_PC:      avs_readdata <= {8'h00, cap_cpu_reg.pc};
        iac_pkg::IAC_OFF_CCR:     avs_readdata <= {24'h000000, cap_cpu_reg.user, 1'b0, cap_cpu_reg.xmask,
                                                   1'b0, cap_cpu_reg.imask, 3'h0};
        iac_pkg::IAC_OFF_STATUS:  avs_readdata <= {12'h000, enable_reg, 12'h000, status_reg};
        default:                  avs_readdata <= iac_pkg::IAC_RD_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_unmapped_illegal: assert property (@(posedge mclk_i) disable iff (rst_i) // R1
    acc_i.valid && acc_i.rgn == iac_pkg::IAC_RGN_UNMAP |-> illegal_o)
    else $error("unmapped access not illegal");

  a_adc_regs_illegal: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    acc_i.valid && is_adc && acc_i.rgn == iac_pkg::IAC_RGN_REGS |-> illegal_o)
    else $error("ADC register access not illegal");

  a_eeprom_write: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    acc_i.valid && is_wr && acc_i.rgn == iac_pkg::IAC_RGN_EEPROM |-> illegal_o)
    else $error("EEPROM write not illegal");

  a_rsvd_core_wr: assert property (@(posedge mclk_i) disable iff (rst_i) // R4
    acc_i.valid && is_core && is_wr && acc_i.rgn == iac_pkg::IAC_RGN_RSVD && !acc_i.nvm_unsup
    |-> illegal_o == !special_mode_i)
    else $error("reserved core write wrong");

  a_collision_illegal: assert property (@(posedge mclk_i) disable iff (rst_i) // R5
    acc_i.valid && acc_i.nvm_unsup |-> illegal_o)
    else $error("collision not illegal");

  a_core_exception: assert property (@(posedge mclk_i) disable iff (rst_i) // R6
    illegal_o && is_core |-> machine_exc_o && !debug_illegal_access_flag_o)
    else $error("core illegal without exception");

  a_debug_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // R7
    debug_illegal_access_flag_o |-> illegal_o && is_dbg && !adc_err_irq_o)
    else $error("debug flag wrong");

  a_adc_irq: assert property (@(posedge mclk_i) disable iff (rst_i) // R8
    illegal_o && is_adc |-> adc_err_irq_o)
    else $error("ADC illegal without error interrupt");

  sequence s_first_viol;
    cap_evt && error_code_capture_reg == iac_pkg::IAC_ERRCODE_RST;
  endsequence

  a_capture_code: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    s_first_viol |=> error_code_capture_reg == $past(code_next) && error_code_capture_reg != 16'h0000)
    else $error("capture code wrong");

  a_capture_frozen: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    error_code_capture_reg != 16'h0000 && !clr_wr |=> $stable(error_code_capture_reg) && $stable(cap_cpu_reg))
    else $error("capture changed while frozen");

  a_regs_exec_ill: assert property (@(posedge mclk_i) disable iff (rst_i) // R2
    acc_i.valid && is_ex && acc_i.rgn == iac_pkg::IAC_RGN_REGS |-> illegal_o)
    else $error("register space execution not illegal");

  a_ram_data_ok: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    acc_i.valid && !is_ex && acc_i.rgn == iac_pkg::IAC_RGN_RAM && !acc_i.nvm_unsup |-> !illegal_o)
    else $error("RAM data access flagged illegal");

  a_info_adc_ill: assert property (@(posedge mclk_i) disable iff (rst_i) // R3
    acc_i.valid && is_adc && acc_i.rgn == iac_pkg::IAC_RGN_INFO |-> illegal_o)
    else $error("ADC info row access not illegal");

  a_prefetch_exc: assert property (@(posedge mclk_i) disable iff (rst_i) // R9
    acc_i.valid && is_core && is_ex && acc_i.rgn == iac_pkg::IAC_RGN_REGS |-> machine_exc_o)
    else $error("illegal prefetch without exception");

  a_core_ecc_exc: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    acc_i.valid && acc_i.ecc_fail && is_core |-> machine_exc_o)
    else $error("core ECC fault without exception");

  a_adc_ecc_exc: assert property (@(posedge mclk_i) disable iff (rst_i) // R11
    acc_i.valid && acc_i.ecc_fail && is_adc |-> machine_exc_o)
    else $error("ADC ECC fault without exception");

  a_debug_ecc_flag: assert property (@(posedge mclk_i) disable iff (rst_i) // R12
    acc_i.valid && acc_i.ecc_fail && is_dbg
    |-> (debug_ram_write_fail_flag_o ^ debug_read_invalid_flag_o) && !machine_exc_o)
    else $error("debug ECC flag wrong");

  a_capture_state: assert property (@(posedge mclk_i) disable iff (rst_i) // R13
    s_first_viol |=> cap_cpu_reg == $past(cpu_i))
    else $error("captured core state wrong");

  a_error_type: assert property (@(posedge mclk_i) disable iff (rst_i) // R14
    s_first_viol
    |=> error_code_capture_reg[3:0] == ($past(illegal) ? iac_pkg::IAC_ERR_ILLEGAL : iac_pkg::IAC_ERR_ECC))
    else $error("captured error type wrong");

  sequence s_clear_only;
    clr_wr && !cap_evt;
  endsequence

  a_clear_key: assert property (@(posedge mclk_i) disable iff (rst_i) // R15
    s_clear_only |=> error_code_capture_reg == iac_pkg::IAC_ERRCODE_RST)
    else $error("capture not cleared by key");

endmodule // iac_checker

// File: hdl/iac_pkg.sv
// Package: constants and types of the illegal access checker
package iac_pkg;

  // Initiators
  typedef enum logic [1:0] {
    IAC_INI_CORE  = 2'h0,
    IAC_INI_DEBUG = 2'h1,
    IAC_INI_ADC   = 2'h2
  } iac_ini_t;

  // Access kinds
  typedef enum logic [1:0] {
    IAC_ACC_READ  = 2'h0,
    IAC_ACC_WRITE = 2'h1,
    IAC_ACC_EXEC  = 2'h2,
    IAC_ACC_VECT  = 2'h3
  } iac_kind_t;

  // Target regions
  typedef enum logic [2:0] {
    IAC_RGN_REGS   = 3'h0,
    IAC_RGN_RAM    = 3'h1,
    IAC_RGN_EEPROM = 3'h2,
    IAC_RGN_RSVD   = 3'h3,
    IAC_RGN_RSVDRO = 3'h4,
    IAC_RGN_INFO   = 3'h5,
    IAC_RGN_PFLASH = 3'h6,
    IAC_RGN_UNMAP  = 3'h7
  } iac_rgn_t;

  // One bus access as seen by the checker
  typedef struct packed {
    logic      valid;
    iac_ini_t  ini;
    iac_kind_t kind;
    iac_rgn_t  rgn;
    logic      nvm_unsup;
    logic      ecc_fail;
  } iac_access_t;

  // Captured core state at a violation
  typedef struct packed {
    logic [23:0] pc;
    logic        user;
    logic        xmask;
    logic        imask;
  } iac_cpu_state_t;

  // Avalon register offsets (byte addresses)
  localparam logic [3:0] IAC_OFF_ERRCODE = 4'h0;
  localparam logic [3:0] IAC_OFF_PC      = 4'h4;
  localparam logic [3:0] IAC_OFF_CCR     = 4'h8;
  localparam logic [3:0] IAC_OFF_STATUS  = 4'hC;

  // Error code fields
  localparam logic [3:0]  IAC_CODE_NONE    = 4'h0;
  localparam logic [3:0]  IAC_ITR_CORE     = 4'h1;
  localparam logic [3:0]  IAC_ITR_ADC      = 4'h3;
  localparam logic [3:0]  IAC_TGT_REGS     = 4'h1;
  localparam logic [3:0]  IAC_TGT_RAM      = 4'h2;
  localparam logic [3:0]  IAC_TGT_EEPROM   = 4'h3;
  localparam logic [3:0]  IAC_TGT_PFLASH   = 4'h4;
  localparam logic [3:0]  IAC_TGT_INFO     = 4'h5;
  localparam logic [3:0]  IAC_ACT_OPCODE   = 4'h1;
  localparam logic [3:0]  IAC_ACT_VECTOR   = 4'h2;
  localparam logic [3:0]  IAC_ACT_LOAD     = 4'h3;
  localparam logic [3:0]  IAC_ACT_STORE    = 4'h4;
  localparam logic [3:0]  IAC_ERR_ILLEGAL  = 4'h1;
  localparam logic [3:0]  IAC_ERR_ECC      = 4'h2;
  localparam logic [15:0] IAC_CLEAR_KEY    = 16'hFFFF;
  localparam logic [15:0] IAC_ERRCODE_RST  = 16'h0000;

  // Unmapped read value
  localparam logic [31:0] IAC_RD_UNMAPPED  = 32'h0000_0000;

endpackage : iac_pkg

// File: verification/iac_initiator_model.sv
// Model of the three bus initiators facing the checker
`timescale 1ns/1ps

module iac_initiator_model (
  // Clock
  input  wire logic               mclk_i,
  // Access toward the checker
  output iac_pkg::iac_access_t    acc_o,
  output iac_pkg::iac_cpu_state_t cpu_o
);
  initial begin
    acc_o = '0;
    cpu_o = '0;
  end

  // Present one access just after an edge
  task automatic drive(input iac_pkg::iac_access_t a, input iac_pkg::iac_cpu_state_t c);
    @(posedge mclk_i);
    acc_o <= a;
    // pc never in last 8 bytes
    cpu_o <= {c.pc & 24'hFFFFF7, c.user, c.xmask, c.imask};
  endtask

  // Release: no stale values left on the lines
  task automatic idle();
    @(posedge mclk_i);
    acc_o <= {1'b0, ~acc_o[8:0]};
    cpu_o <= ~cpu_o;
  endtask
endmodule // iac_initiator_model

// File: verification/testbench.sv
// Self-checking bench of the illegal access checker
`timescale 1ns/1ps

module testbench;
  logic                    mclk_i, rst_i, special_mode_i, avs_read, avs_write;
  logic                    ill_o, mexc_o, adc_o, dia_o, dwf_o, dri_o, irq_o, avs_waitrequest;
  logic [3:0]              avs_address, avs_byteenable;
  logic [31:0]             avs_writedata, avs_readdata;
  iac_pkg::iac_access_t    acc;
  iac_pkg::iac_cpu_state_t cpu;
  int                      num_errors, cmp_count;
  localparam logic [3:0]   TGT [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h0, 4'h5, 4'h4, 4'h0};
  localparam logic [3:0]   ACT [4] = '{4'h3, 4'h4, 4'h1, 4'h2};
  localparam logic [9:0]   CRN [4] = '{10'h010, 10'h06C, 10'h26C, 10'h10D};

  iac_checker iac_checker_inst (.mclk_i(mclk_i), .rst_i(rst_i), .acc_i(acc), .cpu_i(cpu),
    .special_mode_i(special_mode_i), .illegal_o(ill_o), .machine_exc_o(mexc_o), .adc_err_irq_o(adc_o),
    .debug_illegal_access_flag_o(dia_o), .debug_ram_write_fail_flag_o(dwf_o),
    .debug_read_invalid_flag_o(dri_o), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_o(irq_o));
  iac_initiator_model iac_initiator_model_inst (.mclk_i(mclk_i), .acc_o(acc), .cpu_o(cpu));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge mclk_i);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      print_verdict();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  function automatic logic legal(iac_pkg::iac_access_t a, logic ss);
    logic rd, wr, cd;
    rd = a.kind == 2'h0 || a.kind == 2'h3;
    wr = a.kind == 2'h1;
    cd = a.ini != 2'h2;
    case (a.rgn)
      3'h0: return cd && (rd || wr);
      3'h1: return 1'b1;
      3'h2, 3'h6: return !a.nvm_unsup && !wr;
      3'h3: return cd && (rd || (wr && (a.ini == 2'h1 || ss)));
      3'h4: return cd && rd;
      3'h5: return !a.nvm_unsup && cd && rd;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    repeat (100000) @(posedge mclk_i);
    num_errors++;
    print_verdict();
  end

  initial begin
    logic [31:0] q;
    logic [9:0]  v;
    logic [15:0] code;
    logic [31:0] pc, ccr;
    logic [3:0]  sts, en, clr;
    logic        ill, ecc, dbg, ss;
    iac_pkg::iac_access_t    a;
    iac_pkg::iac_cpu_state_t c;
    {rst_i, special_mode_i, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    {num_errors, cmp_count, code, sts, en, pc, ccr} = '0;
    void'($urandom(32'h13BD6190));
    rst_i = 1'b1;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h2, 32'h0, 4'hF, q);
    check(q, iac_pkg::IAC_RD_UNMAPPED);
    for (int i = 0; i < 400; i++) begin
      v[8:7] = $urandom % 3;
      v[6:5] = v[8:7] == 2'h0 ? 2'($urandom % 4) : 2'($urandom % 2);
      v[4:2] = $urandom % 8;
      v[1] = (v[4:2] inside {3'h2, 3'h5, 3'h6}) && ($urandom % 4 == 0);
      v[0] = (v[4:2] inside {3'h1, 3'h6}) && ($urandom % 5 == 0);
      v[9] = $urandom % 2;
      if (i < 4) v = CRN[i];
      a = {1'b1, v[8:0]};
      c = $urandom;
      ss = v[9];
      ecc = a.ecc_fail;
      dbg = a.ini == 2'h1;
      iac_initiator_model_inst.drive(a, c);
      special_mode_i <= ss;
      #1 ill = !legal(a, ss);
      check(ill_o, ill);
      check(mexc_o, (a.ini == 2'h0 && ill) || (ecc && !dbg));
      check(adc_o, a.ini == 2'h2 && ill);
      check({dia_o, dwf_o, dri_o}, {dbg && ill, dbg && ecc && a.kind == 2'h1, dbg && ecc && a.kind != 2'h1});
      if (code == 16'h0 && ((a.ini == 2'h0 && ill) || (ecc && !dbg))) begin
        code = {a.ini == 2'h2 ? 4'h3 : 4'h1, TGT[a.rgn], ACT[a.kind], ill ? 4'h1 : 4'h2};
        pc = {8'h0, c.pc & 24'hFFFFF7};
        ccr = {24'h0, c.user, 1'b0, c.xmask, 1'b0, c.imask, 3'h0};
      end
      sts |= {a.ini == 2'h2 && ill, dbg && ill, ecc, a.ini == 2'h0 && ill};
      iac_initiator_model_inst.idle();
      bus(1'b0, 4'h0, 32'h0, 4'hF, q);
      check(q[15:0], code);
      if (code != 16'h0) begin
        bus(1'b0, 4'h4, 32'h0, 4'hF, q);
        check(q, pc);
        bus(1'b0, 4'h8, 32'h0, 4'hF, q);
        check(q & 32'hA8, ccr);
      end
      bus(1'b0, 4'hC, 32'h0, 4'hF, q);
      check(q & 32'h000F000F, {12'h0, en, 12'h0, sts});
      check(irq_o, |(sts & en));
      if (i % 8 == 5) begin
        en = $urandom;
        clr = $urandom;
        bus(1'b1, 4'hC, {12'h0, en, 4'h0, clr, 8'h0}, 4'h6, q);
        sts &= ~clr;
      end
      if (i % 16 == 7 || i % 16 == 15) begin
        bus(1'b1, 4'h0, i % 16 == 7 ? 32'hFFFF : 32'hFFFE, 4'h3, q);
        if (i % 16 == 7) code = 16'h0;
      end
    end
    print_verdict();
  end
endmodule // testbench
